// [logic/clk_select_stop.sv]
// Purpose: Main, peripheral and CPU clock selection, oscillator start/stop
// Assumes: Oscillators report ticks; APB slave answers with no wait state
// Notes: Oscillators themselves are analog; this drives their enables
//
// Overview of operation
// - Select and mode both 1: high-speed clock drives main and peripherals.
// - Select 0: internal clock for both; select 1 mode 0: peripherals high-speed.
// - High-speed main clock forces high-speed peripheral clock.
// - CPU source 0: CPU runs on divided main system clock.
// - Division codes 000..100 give /1../16; reset code 001 gives /2.
// - Status flags report internal, high-speed or subsystem CPU source.
// - High-speed halt bit 1 stops crystal or disables external input.
// - Stop instruction enters stop state; crystal or external input stops.
// - Stop state also halts the internal high-speed oscillator.
// - Internal halt bit 0 runs internal oscillator, 1 stops it.
// - Accuracy-ready flag rises once internal oscillator has settled.
// - After reset internal oscillator starts and drives the CPU.
// - Pin bits: 0,1 crystal; 1,1 external input; otherwise port.
// - High-speed halt bit 0 starts crystal or enables external input.
`timescale 1ns/1ps
module clk_select_stop (
  input wire logic i_sys_clk, // System clock, 100 MHz
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire clk_ctrl_pkg::apb_req_t i_apb, // APB request
  output clk_ctrl_pkg::apb_rsp_t o_apb, // APB response
  input wire logic i_internal_tick, // Internal oscillator tick
  input wire logic i_highspeed_tick, // High-speed system clock tick
  input wire logic i_subsys_tick, // Subsystem clock tick
  input wire logic i_subsys_select, // Unused; CPU source comes from cpu_source_select
  input wire logic i_stop_exec, // Stop instruction executed, pulse
  input wire logic i_stop_release, // Standby release event, pulse
  output logic o_crystal_osc_en, // Crystal oscillator running
  output logic o_ext_clk_in_en, // External clock input enabled
  output logic o_internal_osc_en, // Internal oscillator running
  output clk_ctrl_pkg::pin_mode_t o_pin_mode, // High-speed pin mode
  output logic o_in_stop, // Stop standby or stabilization wait
  output logic o_cpu_clk_en, // CPU clock tick
  output logic o_periph_clk_en // Peripheral clock tick
);
  import clk_ctrl_pkg::*;

  typedef struct packed {
    logic main_source_select;
    logic main_clock_mode_bit;
    logic cpu_source_select;
    logic [2:0] cpu_div;
    logic highspeed_osc_halt;
    logic internal_osc_halt;
    logic external_input_select;
    logic osc_pin_mode_select;
    logic [2:0] stabilization_time_select;
    logic internal_osc_accuracy_ready;
    logic [15:0] acc_cnt;
    stop_state_t stop_st;
    logic [15:0] stab_cnt;
    logic crystal_en;
    logic ext_en;
    logic internal_en;
    pin_mode_t pin_mode;
    logic in_stop;
    apb_rsp_t apb;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;
  logic int_tick;
  logic hs_tick;
  logic main_tick;
  logic main_cur;
  logic periph_cur;
  logic cpu_main_tick;
  logic cpu_cur;
  logic main_is_highspeed_flag;
  logic subsystem_in_use_flag;
  logic main_sel_hs;
  logic periph_sel_hs;
  logic setup;
  logic access;
  logic [15:0] stab_last;
  logic [31:0] rd_word;
  logic rd_ok;

  // A tick while disabled is dropped
  // Sources only tick while their oscillator or input is enabled
  assign int_tick = i_internal_tick & state_reg.internal_en;
  assign hs_tick = i_highspeed_tick &
                   (state_reg.crystal_en | state_reg.ext_en);

  // Main needs both bits; peripherals follow the select bit alone, which
  // also keeps them on the high-speed clock whenever main uses it
  assign main_sel_hs = state_reg.main_source_select &
                       state_reg.main_clock_mode_bit;
  assign periph_sel_hs = state_reg.main_source_select;

  // Gated ticks: a halted source stalls
  // a changeover, never a runt period
  // Main system clock mux
  clk_switch u_main_sw (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_tick_a(int_tick),
    .i_tick_b(hs_tick),
    .i_sel(main_sel_hs),
    .o_tick(main_tick),
    .o_cur_sel(main_cur)
  );

  // Peripheral hardware clock mux
  clk_switch u_periph_sw (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_tick_a(int_tick),
    .i_tick_b(hs_tick),
    .i_sel(periph_sel_hs),
    .o_tick(o_periph_clk_en),
    .o_cur_sel(periph_cur)
  );

  // Main clock divided for the CPU
  cpu_clk_div u_cpu_div (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_tick(main_tick),
    .i_code(state_reg.cpu_div),
    .o_tick(cpu_main_tick)
  );

  // CPU source mux: divided main clock or subsystem clock
  clk_switch u_cpu_sw (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_tick_a(cpu_main_tick),
    .i_tick_b(i_subsys_tick),
    .i_sel(state_reg.cpu_source_select),
    .o_tick(o_cpu_clk_en),
    .o_cur_sel(cpu_cur)
  );

  // Status flags show the source really in use, not the request
  assign subsystem_in_use_flag = cpu_cur;
  assign main_is_highspeed_flag = main_cur;

  // APB phases; no wait state is added,
  // so every access lasts one cycle
  assign setup = i_apb.psel & ~i_apb.penable;
  assign access = i_apb.psel & i_apb.penable & state_reg.apb.pready;

  // Top select gives 2^15 ticks
  // Stabilization wait length from the select field
  assign stab_last = 16'((17'h00001 << (STAB_BASE_SHIFT +
                     4'(state_reg.stabilization_time_select))) - 17'h00001);

  // Reads show state at the setup edge
  // Read mux; reserved bits read as zero
  always_comb begin
    rd_word = DATA_ZERO;
    rd_ok = 1'b1;
    unique case (i_apb.paddr)
      OFS_MAIN_MODE: begin
        rd_word[MAIN_SRC_BIT] = state_reg.main_source_select;
        rd_word[MAIN_FLAG_BIT] = main_is_highspeed_flag;
        rd_word[MAIN_MODE_BIT] = state_reg.main_clock_mode_bit;
      end
      OFS_CPU_CTRL: begin
        rd_word[CPU_SUB_FLAG_BIT] = subsystem_in_use_flag;
        rd_word[CPU_SRC_BIT] = state_reg.cpu_source_select;
        rd_word[CPU_DIV_LSB +: 3] = state_reg.cpu_div;
      end
      OFS_MAIN_OSC: rd_word[HS_HALT_BIT] = state_reg.highspeed_osc_halt;
      OFS_INT_OSC: begin
        rd_word[INT_READY_BIT] = state_reg.internal_osc_accuracy_ready;
        rd_word[INT_HALT_BIT] = state_reg.internal_osc_halt;
      end
      OFS_PIN_MODE: begin
        rd_word[EXT_SEL_BIT] = state_reg.external_input_select;
        rd_word[PIN_MODE_BIT] = state_reg.osc_pin_mode_select;
      end
      OFS_STAB_SEL: begin
        rd_word[STAB_SEL_LSB +: 3] = state_reg.stabilization_time_select;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Next state of registers, stop sequencing and oscillator enables
  always_comb begin
    state_next = state_reg;
    // APB: answer is prepared in setup, so access lasts one cycle
    state_next.apb.pready = 1'b0;
    if (setup) begin
      state_next.apb.pready = 1'b1;
      state_next.apb.pslverr = ~rd_ok;
      state_next.apb.prdata = i_apb.pwrite ? DATA_ZERO : rd_word;
    end
    // Writes land at the access edge
    if (access && i_apb.pwrite && rd_ok) begin
      unique case (i_apb.paddr)
        OFS_MAIN_MODE: begin
          state_next.main_source_select = i_apb.pwdata[MAIN_SRC_BIT];
          state_next.main_clock_mode_bit = i_apb.pwdata[MAIN_MODE_BIT];
        end
        OFS_CPU_CTRL: begin
          state_next.cpu_source_select = i_apb.pwdata[CPU_SRC_BIT];
          // A prohibited code leaves the stored ratio untouched
          if (i_apb.pwdata[CPU_DIV_LSB +: 3] <= DIV_MAX) begin
            state_next.cpu_div = i_apb.pwdata[CPU_DIV_LSB +: 3];
          end
        end
        OFS_MAIN_OSC: begin
          state_next.highspeed_osc_halt = i_apb.pwdata[HS_HALT_BIT];
        end
        OFS_INT_OSC: begin
          state_next.internal_osc_halt = i_apb.pwdata[INT_HALT_BIT];
        end
        OFS_PIN_MODE: begin
          state_next.external_input_select = i_apb.pwdata[EXT_SEL_BIT];
          state_next.osc_pin_mode_select = i_apb.pwdata[PIN_MODE_BIT];
        end
        OFS_STAB_SEL: begin
          state_next.stabilization_time_select =
            i_apb.pwdata[STAB_SEL_LSB +: 3];
        end
        default: state_next.apb.pslverr = 1'b1;
      endcase
    end

    // Stop standby sequencing
    // Stop is taken only while running
    unique case (state_reg.stop_st)
      ST_RUN: begin
        // Enables fall one cycle later
        if (i_stop_exec) begin
          state_next.stop_st = ST_STOPPED;
        end
      end
      ST_STOPPED: begin
        state_next.stab_cnt = 16'h0000;
        if (i_stop_release) begin
          // Only a crystal-fed CPU has to wait for the resonator
          if (state_reg.pin_mode == PIN_CRYSTAL && main_cur && !cpu_cur &&
              !state_reg.highspeed_osc_halt) begin
            state_next.stop_st = ST_STAB_WAIT;
          end else begin
            state_next.stop_st = ST_RUN;
          end
        end
      end
      ST_STAB_WAIT: begin
        // Raw ticks: crystal not yet trusted
        if (i_highspeed_tick) begin
          if (state_reg.stab_cnt >= stab_last) begin
            state_next.stop_st = ST_RUN;
          end else begin
            state_next.stab_cnt = state_reg.stab_cnt + 16'h0001;
          end
        end
      end
      default: state_next.stop_st = ST_RUN;
    endcase
    // Registered stop flag, same timing
    state_next.in_stop = state_next.stop_st != ST_RUN;

    // Pin mode from the two selection bits
    if (!state_reg.osc_pin_mode_select) begin
      state_next.pin_mode = PIN_PORT;
    end else if (state_reg.external_input_select) begin
      state_next.pin_mode = PIN_EXT;
    end else begin
      state_next.pin_mode = PIN_CRYSTAL;
    end

    // Nothing refuses halting the CPU's
    // own source; software checks flags
    // High-speed source runs unless halted or in stop; the wait state
    // restarts the crystal so it can settle
    state_next.crystal_en = state_reg.pin_mode == PIN_CRYSTAL &&
      !state_reg.highspeed_osc_halt &&
      state_reg.stop_st != ST_STOPPED;
    state_next.ext_en = state_reg.pin_mode == PIN_EXT &&
      !state_reg.highspeed_osc_halt &&
      state_reg.stop_st == ST_RUN;
    state_next.internal_en = !state_reg.internal_osc_halt &&
      state_reg.stop_st == ST_RUN;

    // Ready falls once the osc stops
    // Accuracy settles after a fixed count of ticks from each start
    if (!state_reg.internal_en) begin
      state_next.acc_cnt = 16'h0000;
      state_next.internal_osc_accuracy_ready = 1'b0;
    end else if (i_internal_tick && !state_reg.internal_osc_accuracy_ready)
    begin
      if (state_reg.acc_cnt >= ACC_TICKS - 16'h0001) begin
        state_next.internal_osc_accuracy_ready = 1'b1;
      end else begin
        state_next.acc_cnt = state_reg.acc_cnt + 16'h0001;
      end
    end
  end

  // State register; internal oscillator runs and feeds the CPU from reset
  // Reset values are all constants
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg.main_source_select <= 1'b0;
      state_reg.main_clock_mode_bit <= 1'b0;
      state_reg.cpu_source_select <= 1'b0;
      state_reg.cpu_div <= DIV_RESET;
      state_reg.highspeed_osc_halt <= HS_HALT_RESET;
      state_reg.internal_osc_halt <= INT_HALT_RESET;
      state_reg.external_input_select <= 1'b0;
      state_reg.osc_pin_mode_select <= 1'b0;
      state_reg.stabilization_time_select <= STAB_SEL_RESET;
      state_reg.internal_osc_accuracy_ready <= 1'b0;
      state_reg.acc_cnt <= 16'h0000;
      state_reg.stop_st <= ST_RUN;
      state_reg.stab_cnt <= 16'h0000;
      state_reg.crystal_en <= 1'b0;
      state_reg.ext_en <= 1'b0;
      state_reg.internal_en <= 1'b1;
      state_reg.pin_mode <= PIN_PORT;
      state_reg.in_stop <= 1'b0;
      state_reg.apb <= '{prdata: DATA_ZERO, pready: 1'b0, pslverr: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // o_in_stop is a flop of its own
  // Outputs straight from registers
  assign o_apb = state_reg.apb;
  assign o_crystal_osc_en = state_reg.crystal_en;
  assign o_ext_clk_in_en = state_reg.ext_en;
  assign o_internal_osc_en = state_reg.internal_en;
  assign o_pin_mode = state_reg.pin_mode;
  assign o_in_stop = state_reg.in_stop;
endmodule : clk_select_stop

// [shared/clk_ctrl_pkg.sv]
// Purpose: Shared constants and types for the system clock select block
// Assumes: One 100 MHz system clock; clock sources arrive as tick enables
// Notes: Register offsets are byte addresses on a 32-bit APB
package clk_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MAIN_MODE = 8'h00;
  localparam logic [7:0] OFS_CPU_CTRL = 8'h04;
  localparam logic [7:0] OFS_MAIN_OSC = 8'h08;
  localparam logic [7:0] OFS_INT_OSC = 8'h0c;
  localparam logic [7:0] OFS_PIN_MODE = 8'h10;
  localparam logic [7:0] OFS_STAB_SEL = 8'h14;
  // Field positions
  localparam int MAIN_MODE_BIT = 0;
  localparam int MAIN_FLAG_BIT = 1;
  localparam int MAIN_SRC_BIT = 2;
  localparam int CPU_DIV_LSB = 0;
  localparam int CPU_SRC_BIT = 4;
  localparam int CPU_SUB_FLAG_BIT = 5;
  localparam int HS_HALT_BIT = 7;
  localparam int INT_HALT_BIT = 0;
  localparam int INT_READY_BIT = 7;
  localparam int PIN_MODE_BIT = 6;
  localparam int EXT_SEL_BIT = 7;
  localparam int STAB_SEL_LSB = 0;
  // Reset values and limits
  localparam logic [2:0] DIV_RESET = 3'h1;
  localparam logic [2:0] DIV_MAX = 3'h4;
  localparam logic HS_HALT_RESET = 1'b1;
  localparam logic INT_HALT_RESET = 1'b0;
  localparam logic [2:0] STAB_SEL_RESET = 3'h4;
  // Internal oscillator ticks until its accuracy is settled
  localparam logic [15:0] ACC_TICKS = 16'h0040;
  // Stabilization wait is 2^(base + select) high-speed ticks
  localparam logic [3:0] STAB_BASE_SHIFT = 4'h8;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    PIN_PORT = 2'b00,
    PIN_CRYSTAL = 2'b01,
    PIN_EXT = 2'b10
  } pin_mode_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOPPED = 2'b01,
    ST_STAB_WAIT = 2'b10
  } stop_state_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_DRAIN = 2'b01,
    SW_ACQ = 2'b10
  } switch_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
endpackage : clk_ctrl_pkg

// [logic/clk_switch.sv]
// Purpose: Glitch-free changeover between two clock tick sources
// Assumes: Ticks are one-cycle enables synchronous to i_sys_clk
// Notes: A changeover waits for a tick of the old source, then the new one
`timescale 1ns/1ps
module clk_switch (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire logic i_tick_a, // Source 0 tick
  input wire logic i_tick_b, // Source 1 tick
  input wire logic i_sel, // Requested source
  output logic o_tick, // Selected tick, registered
  output logic o_cur_sel // Source actually in use
);
  import clk_ctrl_pkg::*;

  typedef struct packed {
    switch_state_t st;
    logic cur;
    logic tick;
  } sw_state_t;

  sw_state_t state_reg;
  sw_state_t state_next;
  logic old_tick;
  logic new_tick;

  // Old and new ticks seen from the source in use
  assign old_tick = state_reg.cur ? i_tick_b : i_tick_a;
  assign new_tick = state_reg.cur ? i_tick_a : i_tick_b;

  // No tick passes between the old source's last edge and the new first
  // edge, so no runt period reaches the load; a dead old source stalls it
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    unique case (state_reg.st)
      SW_IDLE: begin
        if (i_sel != state_reg.cur) begin
          state_next.st = SW_DRAIN;
        end else begin
          state_next.tick = old_tick;
        end
      end
      SW_DRAIN: begin
        if (old_tick) begin
          state_next.st = SW_ACQ;
        end
      end
      SW_ACQ: begin
        if (new_tick) begin
          state_next.cur = ~state_reg.cur;
          state_next.st = SW_IDLE;
        end
      end
      default: state_next.st = SW_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '{st: SW_IDLE, cur: 1'b0, tick: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_tick = state_reg.tick;
  assign o_cur_sel = state_reg.cur;
endmodule : clk_switch

// [logic/cpu_clk_div.sv]
// Purpose: Power-of-two divider for the CPU clock tick
// Assumes: Input tick is a one-cycle enable
// Notes: A prohibited code keeps the ratio that was last valid
`timescale 1ns/1ps
module cpu_clk_div (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire logic i_tick, // Main system clock tick
  input wire logic [2:0] i_code, // Requested division code
  output logic o_tick // Divided tick, registered
);
  import clk_ctrl_pkg::*;

  typedef struct packed {
    logic [2:0] code;
    logic [3:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t state_reg;
  div_state_t state_next;
  logic [3:0] last;

  // Terminal count is 2^code - 1
  assign last = 4'((5'h01 << state_reg.code) - 5'h01);

  // Ratio changes only at a period boundary to keep periods whole
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (i_tick) begin
      if (state_reg.cnt >= last) begin
        state_next.cnt = 4'h0;
        state_next.tick = 1'b1;
        if (i_code <= DIV_MAX) begin
          state_next.code = i_code;
        end
      end else begin
        state_next.cnt = state_reg.cnt + 4'h1;
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '{code: DIV_RESET, cnt: 4'h0, tick: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_tick = state_reg.tick;
endmodule : cpu_clk_div

// [verif/clk_select_stop_chk.sv]
// Purpose: Port-level checks of clock select and stop
// Assumes: Single clock domain, async active-low reset
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
module clk_select_stop_chk (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire clk_ctrl_pkg::apb_req_t i_apb, // APB request
  input wire clk_ctrl_pkg::apb_rsp_t o_apb, // APB response
  input wire logic i_stop_exec, // Stop pulse
  input wire logic i_stop_release, // Release pulse
  input wire logic o_crystal_osc_en, // Crystal on
  input wire logic o_ext_clk_in_en, // External input on
  input wire logic o_internal_osc_en, // Internal on
  input wire clk_ctrl_pkg::pin_mode_t o_pin_mode, // Pin mode
  input wire logic o_in_stop // Stop state
);
  import clk_ctrl_pkg::*;
  logic mapped;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Offsets past the last register or unaligned are refused
  assign mapped = (i_apb.paddr <= OFS_STAB_SEL) && (i_apb.paddr[1:0] == 2'b00);
  sequence s_setup;
    i_apb.psel && !i_apb.penable;
  endsequence
  sequence s_stop_go;
    i_stop_exec && !o_in_stop;
  endsequence
  a_ready_one_cycle: assert property (s_setup |=>
    o_apb.pready ##1 !o_apb.pready)
    else $error("pready not a single cycle after setup");
  a_unmapped_error: assert property (s_setup ##0 !mapped |=>
    o_apb.pslverr && o_apb.prdata == DATA_ZERO)
    else $error("unmapped access not refused");
  a_pin_legal: assert property (o_pin_mode != 2'b11)
    else $error("pin mode code out of range");
  a_one_hs_path: assert property (!(o_crystal_osc_en &&
    o_ext_clk_in_en))
    else $error("crystal and external input both on");
  a_stop_enter: assert property (s_stop_go |=> o_in_stop)
    else $error("stop state not entered");
  a_stop_halts: assert property (s_stop_go |=> ##1
    !(o_internal_osc_en || o_crystal_osc_en || o_ext_clk_in_en))
    else $error("oscillator still on in stop");
  // The settle wait, with the crystal on, ends by itself after its count of raw high-speed ticks
  a_stop_holds: assert property (o_in_stop && !o_crystal_osc_en &&
    !i_stop_release |=> o_in_stop)
    else $error("stop state left without release");
  a_reset_int_on: assert property ($rose(i_rst_n) |->
    o_internal_osc_en)
    else $error("internal oscillator off after reset");
endmodule : clk_select_stop_chk

bind clk_select_stop clk_select_stop_chk chk (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .i_apb(i_apb), .o_apb(o_apb), .i_stop_exec(i_stop_exec),
  .i_stop_release(i_stop_release), .o_crystal_osc_en(o_crystal_osc_en),
  .o_ext_clk_in_en(o_ext_clk_in_en), .o_internal_osc_en(o_internal_osc_en),
  .o_pin_mode(o_pin_mode), .o_in_stop(o_in_stop));

// [verif/system_clock_select_and_stop_tb_top.sv]
// Purpose: Self-checking bench for clock select and stop
// Assumes: Ticks are made here; bench is the APB master
// Notes: Random tick streams, seed fixed for repeatable runs
`timescale 1ns/1ps
module system_clock_select_and_stop_tb_top;
  import clk_ctrl_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic itk = 0, htk = 0, stk = 0, sexec = 0, srel = 0;
  logic xen, een, ien, stp, cpu, per;
  pin_mode_t pm;
  int imode = 1, hmode = 1, miscompares = 0, checks = 0;
  logic [31:0] rd;
  logic er;
  int cp, pp, p;
  logic [2:0] prev;
  logic [2:0] codes [6] = '{3'h4, 3'h0, 3'h3, 3'h5, 3'h1, 3'h2};

  clk_select_stop dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_apb(req),
    .o_apb(rsp), .i_internal_tick(itk), .i_highspeed_tick(htk),
    .i_subsys_tick(stk), .i_subsys_select(1'b0), .i_stop_exec(sexec),
    .i_stop_release(srel), .o_crystal_osc_en(xen), .o_ext_clk_in_en(een),
    .o_internal_osc_en(ien), .o_pin_mode(pm), .o_in_stop(stp),
    .o_cpu_clk_en(cpu), .o_periph_clk_en(per));

  always #5 clk = ~clk;
  // Tick streams: 0 off, 1 random, 2 every cycle
  always @(posedge clk) begin
    itk <= (imode == 2) || (imode == 1 && $urandom % 3 == 0);
    htk <= (hmode == 2) || (hmode == 1 && $urandom % 2 == 0);
    stk <= ($urandom % 4 == 0);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // One APB transfer; the answer is taken at the edge pready is high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req.psel <= 1; req.penable <= 0; req.pwrite <= w;
    req.paddr <= a; req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) miscompares++;
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 0; req.penable <= 0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(0, a, 0);
    check(rd & m, e);
  endtask : rdc

  // Poll a register until masked bits equal a value, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    int n;
    n = 0;
    do begin
      apb(0, a, 0);
      n++;
    end while ((rd & m) !== e && n < 300);
  endtask : poll

  task automatic count(input int n);
    cp = 0; pp = 0;
    repeat (4) @(negedge clk); // Let ticks in flight drain
    repeat (n) begin
      @(negedge clk);
      cp += cpu; pp += per;
    end
  endtask : count

  // Cycles between two CPU ticks
  task automatic period;
    int n;
    n = 0; p = 0;
    do begin @(negedge clk); n++; end while (cpu !== 1'b1 && n < 100);
    do begin @(negedge clk); p++; end while (cpu !== 1'b1 && p < 100);
  endtask : period

  function automatic logic [1:0] pin_exp(input int v);
    return (v == 1) ? PIN_CRYSTAL : (v == 3) ? PIN_EXT : PIN_PORT;
  endfunction : pin_exp

  initial begin
    #200us;
    miscompares++;
    report_and_stop();
  end

  initial begin
    void'($urandom(43));
    repeat (2) @(posedge clk);
    rst_n <= 1;
    // Reset values and an unmapped place
    check(ien, 1);
    rdc(OFS_MAIN_MODE, 32'hffffffff, 0);
    rdc(OFS_CPU_CTRL, 32'hffffffff, 32'h1);
    rdc(OFS_MAIN_OSC, 32'hffffffff, 32'h80);
    rdc(OFS_INT_OSC, 32'h1, 0);
    rdc(OFS_STAB_SEL, 32'hffffffff, 32'h4);
    apb(0, 8'h18, 0);
    check(er, 1);
    $display("reset test done");
    // Pin modes, changed only while the high-speed clock is halted
    for (int v = 0; v < 4; v++) begin
      apb(1, OFS_PIN_MODE, v << 6);
      repeat (2) @(negedge clk);
      check(pm, pin_exp(v));
    end
    foreach (codes[i]) begin
      apb(1, OFS_PIN_MODE, i[0] ? 32'hc0 : 32'h40);
      apb(1, OFS_MAIN_OSC, 0);
      repeat (2) @(negedge clk);
      check({xen, een}, i[0] ? 2'b01 : 2'b10);
      apb(1, OFS_MAIN_OSC, 32'h80);
      repeat (2) @(negedge clk);
      check({xen, een}, 2'b00);
    end
    $display("pin test done");
    // Random stabilization select values, set while not in stop
    repeat (4) begin
      prev = 3'($urandom % 8);
      apb(1, OFS_STAB_SEL, prev);
      rdc(OFS_STAB_SEL, 32'hffffffff, prev);
    end
    // Divider ratios with a prohibited code among them
    imode = 2; hmode = 0; prev = 3'h1;
    foreach (codes[i]) begin
      apb(1, OFS_CPU_CTRL, codes[i]);
      if (codes[i] <= DIV_MAX) prev = codes[i];
      rdc(OFS_CPU_CTRL, 32'h17, prev);
      period();
      period();
      check(p, 1 << prev);
    end
    $display("divider test done");
    // CPU onto the subsystem clock and back
    apb(1, OFS_CPU_CTRL, 32'h10 | prev);
    poll(OFS_CPU_CTRL, 32'h20, 32'h20);
    rdc(OFS_CPU_CTRL, 32'h37, 32'h30 | prev);
    imode = 0;
    count(30);
    check(cp > 0 && pp == 0, 1);
    imode = 2;
    apb(1, OFS_CPU_CTRL, prev);
    poll(OFS_CPU_CTRL, 32'h20, 0);
    check(rd & 32'h20, 0);
    // Main clock onto the high-speed source
    imode = 1; hmode = 1;
    apb(1, OFS_PIN_MODE, 32'h40);
    apb(1, OFS_MAIN_OSC, 0);
    apb(1, OFS_MAIN_MODE, 32'h5);
    poll(OFS_MAIN_MODE, 32'h2, 32'h2);
    rdc(OFS_MAIN_MODE, 32'hffffffff, 32'h7);
    imode = 2; hmode = 0;
    count(30);
    check(pp + cp, 0);
    imode = 0; hmode = 2;
    count(30);
    check(pp > 0 && cp > 0, 1);
    // Internal oscillator halt and restart
    imode = 1;
    apb(1, OFS_INT_OSC, 32'h1);
    repeat (3) @(negedge clk);
    check(ien, 0);
    rdc(OFS_INT_OSC, 32'h80, 0);
    apb(1, OFS_INT_OSC, 0);
    repeat (3) @(negedge clk);
    check(ien, 1);
    rdc(OFS_INT_OSC, 32'h80, 0);
    poll(OFS_INT_OSC, 32'h80, 32'h80);
    check(rd[7], 1);
    $display("high-speed test done");
    // Select 1 mode 0, then select 0
    hmode = 1;
    apb(1, OFS_MAIN_MODE, 32'h4);
    poll(OFS_MAIN_MODE, 32'h2, 0);
    imode = 2; hmode = 0;
    count(30);
    check(pp, 0);
    hmode = 1;
    apb(1, OFS_MAIN_MODE, 0);
    repeat (40) @(negedge clk);
    hmode = 0;
    count(30);
    check(pp > 0 && cp > 0, 1);
    // Stop instruction with the CPU on the internal clock
    apb(1, OFS_MAIN_OSC, 32'h80);
    @(posedge clk);
    sexec <= 1;
    @(posedge clk);
    sexec <= 0;
    repeat (3) @(negedge clk);
    check({stp, ien, xen, een}, 4'b1000);
    @(posedge clk);
    srel <= 1;
    @(posedge clk);
    srel <= 0;
    repeat (4) @(negedge clk);
    check({stp, ien}, 2'b01);
    $display("stop test done");
    // Stop on crystal: release waits 2^8 raw ticks
    hmode = 2;
    apb(1, OFS_MAIN_OSC, 0);
    apb(1, OFS_STAB_SEL, 0);
    apb(1, OFS_MAIN_MODE, 32'h5);
    poll(OFS_MAIN_MODE, 32'h2, 32'h2);
    @(posedge clk);
    sexec <= 1;
    @(posedge clk);
    sexec <= 0;
    srel <= 1;
    @(posedge clk);
    srel <= 0;
    repeat (100) @(negedge clk);
    check({stp, xen}, 2'b11);
    repeat (200) @(negedge clk);
    check({stp, xen}, 2'b01);
    $display("crystal stop test done");
    report_and_stop();
  end
endmodule : system_clock_select_and_stop_tb_top
